/* pkg/eamt_pkg.sv */
package eamt_pkg;

    // addressing modes of an operand
    typedef enum logic [3:0] {
        EAMT_DREG,
        EAMT_AREG,
        EAMT_IND,
        EAMT_POSTINC,
        EAMT_PREDEC,
        EAMT_DISP,
        EAMT_INDEX,
        EAMT_ABS_W,
        EAMT_ABS_L,
        EAMT_PC_DISP,
        EAMT_PC_INDEX,
        EAMT_IMM
    } eamt_mode_t;

    // job kind: address evaluation only, or a full move
    typedef enum logic {
        EAMT_KIND_EA,
        EAMT_KIND_MOVE
    } eamt_kind_t;

    typedef struct packed {
        eamt_kind_t kind;
        logic       long_sz;
        eamt_mode_t src;
        eamt_mode_t dst;
    } eamt_req_t;

    // clocks with the read and write bus cycles included in them
    typedef struct packed {
        logic [5:0] clocks;
        logic [2:0] reads;
        logic [1:0] writes;
    } eamt_time_t;

    localparam int         EAMT_NUM_MODES = 12;
    localparam int         EAMT_BUS_CLKS  = 4;     // clocks per bus cycle
    localparam logic [1:0] EAMT_PH_FIRST  = 2'h0;
    localparam logic [1:0] EAMT_PH_LAST   = 2'h3;

    // address evaluation, byte and word
    localparam eamt_time_t EAMT_EA_W [EAMT_NUM_MODES] = '{
        '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}, '{6'h04, 3'h1, 2'h0},
        '{6'h04, 3'h1, 2'h0}, '{6'h06, 3'h1, 2'h0}, '{6'h08, 3'h2, 2'h0},
        '{6'h0A, 3'h2, 2'h0}, '{6'h08, 3'h2, 2'h0}, '{6'h0C, 3'h3, 2'h0},
        '{6'h08, 3'h2, 2'h0}, '{6'h0A, 3'h2, 2'h0}, '{6'h04, 3'h1, 2'h0}};

    // address evaluation, long
    localparam eamt_time_t EAMT_EA_L [EAMT_NUM_MODES] = '{
        '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}, '{6'h08, 3'h2, 2'h0},
        '{6'h08, 3'h2, 2'h0}, '{6'h0A, 3'h2, 2'h0}, '{6'h0C, 3'h3, 2'h0},
        '{6'h0E, 3'h3, 2'h0}, '{6'h0C, 3'h3, 2'h0}, '{6'h10, 3'h4, 2'h0},
        '{6'h0C, 3'h3, 2'h0}, '{6'h0E, 3'h3, 2'h0}, '{6'h08, 3'h2, 2'h0}};

    // move destination cost, byte and word
    localparam eamt_time_t EAMT_DST_W [EAMT_NUM_MODES] = '{
        '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}, '{6'h04, 3'h0, 2'h1},
        '{6'h04, 3'h0, 2'h1}, '{6'h04, 3'h0, 2'h1}, '{6'h08, 3'h1, 2'h1},
        '{6'h0A, 3'h1, 2'h1}, '{6'h08, 3'h1, 2'h1}, '{6'h0C, 3'h2, 2'h1},
        '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}};

    // move destination cost, long (register source for pre-decrement)
    localparam eamt_time_t EAMT_DST_L [EAMT_NUM_MODES] = '{
        '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}, '{6'h08, 3'h0, 2'h2},
        '{6'h08, 3'h0, 2'h2}, '{6'h0A, 3'h0, 2'h2}, '{6'h0C, 3'h1, 2'h2},
        '{6'h0E, 3'h1, 2'h2}, '{6'h0C, 3'h1, 2'h2}, '{6'h10, 3'h2, 2'h2},
        '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}, '{6'h00, 3'h0, 2'h0}};

    // long pre-decrement store after a memory source overlaps the decrement
    localparam eamt_time_t EAMT_DST_PREDEC_MEM_L = '{6'h08, 3'h0, 2'h2};

    // opcode fetch common to every move, one read and no internal clocks
    localparam eamt_time_t EAMT_MOVE_BASE = '{6'h04, 3'h1, 2'h0};

endpackage

/* core/eamt_time_rom.sv */
`timescale 1ns/1ps
module eamt_time_rom (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // lookup request
    input  wire logic                 look_i,
    input  wire eamt_pkg::eamt_req_t  req_i,
    // registered answer, valid one cycle after look_i
    output eamt_pkg::eamt_time_t      time_o,
    output logic                      valid_o
);
    import eamt_pkg::*;

    eamt_time_t time_d;
    eamt_time_t time_q;
    logic       valid_d;
    logic       valid_q;

    function automatic eamt_time_t add_time(eamt_time_t a, eamt_time_t b);
        eamt_time_t s;
        s.clocks = a.clocks + b.clocks;
        s.reads  = a.reads + b.reads;
        s.writes = a.writes + b.writes;
        return s;
    endfunction

    // table lookup: address part, then move base and store part
    always_comb begin
        eamt_time_t ea;
        eamt_time_t dst;
        ea  = req_i.long_sz ? EAMT_EA_L[req_i.src] : EAMT_EA_W[req_i.src];
        dst = req_i.long_sz ? EAMT_DST_L[req_i.dst] : EAMT_DST_W[req_i.dst];
        if (req_i.long_sz && req_i.dst == EAMT_PREDEC &&
            req_i.src != EAMT_DREG && req_i.src != EAMT_AREG) begin
            dst = EAMT_DST_PREDEC_MEM_L;
        end
        time_d  = time_q;
        valid_d = look_i;
        if (look_i) begin
            if (req_i.kind == EAMT_KIND_EA) begin
                time_d = ea;
            end else begin
                time_d = add_time(add_time(EAMT_MOVE_BASE, ea), dst);
            end
        end
    end

    // read data leave from a register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            time_q  <= '0;
            valid_q <= 1'b0;
        end else begin
            time_q  <= time_d;
            valid_q <= valid_d;
        end
    end

    assign time_o  = time_q;
    assign valid_o = valid_q;

endmodule // eamt_time_rom

/* core/eamt_seq.sv */
`timescale 1ns/1ps
// Overview of operation
// - all times are counted in clocks, a bus cycle taking four of them.
// - memory stretches a bus cycle by wait states that add to the total.
// - a figure is r reads and w writes of four clocks plus internal clocks.
// - move totals include the opcode fetch and every operand fetch and store.
// - address evaluation fetches extensions and operand, never writes.
// - plain and post-increment indirect take 4(1/0), long 8(2/0).
// - pre-decrement indirect takes 6(1/0), long 10(2/0).
// - displacement, absolute short, pc displacement 8(2/0), long 12(3/0).
// - address indexed takes 10(2/0), long 14(3/0), any index size.
// - pc indexed takes 10(2/0), long 14(3/0).
// - word moves: reg-reg 4(1/0), reg-ind 8(1/1), abs-abs 28(6/1).
// - long moves: reg-ind 12(1/2), reg-predec 14, abs-abs 36(7/2).
module eamt_seq #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // job request
    input  wire logic                 req_valid,
    input  wire eamt_pkg::eamt_req_t  req,
    output logic                      req_ready,
    // processor bus
    output logic                      bus_cyc,
    output logic                      bus_write,
    output logic [1:0]                bus_phase,
    input  wire logic                 mem_wait,
    // job result
    output logic                      done,
    output logic [CNT_W-1:0]          total_clks,
    output logic [CNT_W-1:0]          wait_clks,
    output logic [2:0]                reads_done,
    output logic [1:0]                writes_done
);
    import eamt_pkg::*;

    if (CNT_W < 8) begin : g_chk
        $error("CNT_W too small for the longest move");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOOK,
        ST_READ,
        ST_INT,
        ST_WRITE,
        ST_DONE
    } eamt_state_t;

    eamt_state_t      state_q, state_d;
    logic [1:0]       phase_q, phase_d;
    logic [2:0]       rd_left_q, rd_left_d;
    logic [1:0]       wr_left_q, wr_left_d;
    logic [5:0]       int_left_q, int_left_d;
    logic [CNT_W-1:0] elapsed_q, elapsed_d;
    logic [CNT_W-1:0] waits_q, waits_d;
    logic [2:0]       rd_cnt_q, rd_cnt_d;
    logic [1:0]       wr_cnt_q, wr_cnt_d;
    eamt_time_t       fixed_q, fixed_d;
    eamt_req_t        job_q, job_d;
    eamt_time_t       rom_time;
    logic             rom_valid;
    logic             accept;
    logic             bus_last;
    logic             counting;
    logic [5:0]       int_clks;

    assign accept = req_valid && req_ready;

    eamt_time_rom u_rom (
        .core_clk (core_clk),
        .nrst     (nrst),
        .look_i   (accept),
        .req_i    (req),
        .time_o   (rom_time),
        .valid_o  (rom_valid)
    );

    // clocks of the figure not spent on the bus
    assign int_clks = rom_time.clocks
                    - 6'(rom_time.reads * EAMT_BUS_CLKS)
                    - 6'(rom_time.writes * EAMT_BUS_CLKS);

    assign bus_last = (phase_q == EAMT_PH_LAST);
    assign counting = (state_q == ST_READ) || (state_q == ST_INT) ||
                      (state_q == ST_WRITE);

    // stage order: reads, internal work, writes
    function automatic eamt_state_t next_stage(logic [2:0] rd,
                                               logic [5:0] it,
                                               logic [1:0] wr);
        if (rd != 3'h0) return ST_READ;
        if (it != 6'h00) return ST_INT;
        if (wr != 2'h0) return ST_WRITE;
        return ST_DONE;
    endfunction

    // sequencer next state
    always_comb begin
        state_d    = state_q;
        phase_d    = phase_q;
        rd_left_d  = rd_left_q;
        wr_left_d  = wr_left_q;
        int_left_d = int_left_q;
        elapsed_d  = elapsed_q;
        waits_d    = waits_q;
        rd_cnt_d   = rd_cnt_q;
        wr_cnt_d   = wr_cnt_q;
        fixed_d    = fixed_q;
        job_d      = job_q;
        if (counting && elapsed_q != {CNT_W{1'b1}}) begin
            elapsed_d = elapsed_q + 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    job_d     = req;
                    elapsed_d = '0;
                    waits_d   = '0;
                    rd_cnt_d  = 3'h0;
                    wr_cnt_d  = 2'h0;
                    state_d   = ST_LOOK;
                end
            end
            ST_LOOK: begin
                if (rom_valid) begin
                    fixed_d    = rom_time;
                    rd_left_d  = rom_time.reads;
                    wr_left_d  = rom_time.writes;
                    int_left_d = int_clks;
                    phase_d    = EAMT_PH_FIRST;
                    state_d    = next_stage(rom_time.reads, int_clks,
                                            rom_time.writes);
                end
            end
            ST_READ, ST_WRITE: begin
                if (!bus_last) begin
                    phase_d = phase_q + 2'h1;
                end else if (mem_wait) begin
                    // step held, clock still counted
                    if (waits_q != {CNT_W{1'b1}}) begin
                        waits_d = waits_q + 1'b1;
                    end
                end else begin
                    phase_d = EAMT_PH_FIRST;
                    if (state_q == ST_READ) begin
                        rd_left_d = rd_left_q - 3'h1;
                        rd_cnt_d  = rd_cnt_q + 3'h1;
                        state_d   = next_stage(rd_left_d, int_left_q,
                                               wr_left_q);
                    end else begin
                        wr_left_d = wr_left_q - 2'h1;
                        wr_cnt_d  = wr_cnt_q + 2'h1;
                        state_d   = next_stage(3'h0, 6'h00, wr_left_d);
                    end
                end
            end
            ST_INT: begin
                int_left_d = int_left_q - 6'h01;
                state_d    = next_stage(3'h0, int_left_d, wr_left_q);
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= ST_IDLE;
            phase_q    <= EAMT_PH_FIRST;
            rd_left_q  <= 3'h0;
            wr_left_q  <= 2'h0;
            int_left_q <= 6'h00;
            elapsed_q  <= '0;
            waits_q    <= '0;
            rd_cnt_q   <= 3'h0;
            wr_cnt_q   <= 2'h0;
            fixed_q    <= '0;
            job_q      <= '0;
        end else begin
            state_q    <= state_d;
            phase_q    <= phase_d;
            rd_left_q  <= rd_left_d;
            wr_left_q  <= wr_left_d;
            int_left_q <= int_left_d;
            elapsed_q  <= elapsed_d;
            waits_q    <= waits_d;
            rd_cnt_q   <= rd_cnt_d;
            wr_cnt_q   <= wr_cnt_d;
            fixed_q    <= fixed_d;
            job_q      <= job_d;
        end
    end

    // outputs
    assign req_ready   = (state_q == ST_IDLE);
    assign bus_cyc     = (state_q == ST_READ) || (state_q == ST_WRITE);
    assign bus_write   = (state_q == ST_WRITE);
    assign bus_phase   = phase_q;
    assign done        = (state_q == ST_DONE);
    assign total_clks  = elapsed_q;
    assign wait_clks   = waits_q;
    assign reads_done  = rd_cnt_q;
    assign writes_done = wr_cnt_q;

    // checks on the sequencer
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    phase_step_a: assert property (bus_cyc && !bus_last
        |=> bus_cyc && phase_q == $past(phase_q) + 2'h1)
        else $error("bus phase did not advance");
    wait_hold_a: assert property (bus_cyc && bus_last && mem_wait
        |=> bus_cyc && bus_last && waits_q == $past(waits_q) + 1'b1)
        else $error("stretched cycle not held");
    total_sum_a: assert property (done
        |-> elapsed_q == CNT_W'(fixed_q.clocks) + waits_q)
        else $error("total clocks mismatch");
    bus_count_a: assert property (done
        |-> rd_cnt_q == fixed_q.reads && wr_cnt_q == fixed_q.writes)
        else $error("bus cycle count mismatch");
    ea_no_write_a: assert property (job_q.kind == EAMT_KIND_EA
        |-> !bus_write)
        else $error("write during address evaluation");
    ind_time_a: assert property (rom_valid && job_q.kind == EAMT_KIND_EA &&
        (job_q.src == EAMT_IND || job_q.src == EAMT_POSTINC)
        |-> rom_time == (job_q.long_sz ? EAMT_EA_L[EAMT_IND]
                                       : EAMT_EA_W[EAMT_IND])
            && rom_time.reads == (job_q.long_sz ? 3'h2 : 3'h1))
        else $error("indirect timing wrong");
    predec_time_a: assert property (rom_valid &&
        job_q.kind == EAMT_KIND_EA && job_q.src == EAMT_PREDEC
        |-> rom_time.clocks == (job_q.long_sz ? 6'h0A : 6'h06))
        else $error("pre-decrement timing wrong");
    disp_time_a: assert property (rom_valid && job_q.kind == EAMT_KIND_EA &&
        (job_q.src == EAMT_DISP || job_q.src == EAMT_ABS_W ||
         job_q.src == EAMT_PC_DISP)
        |-> rom_time.clocks == (job_q.long_sz ? 6'h0C : 6'h08))
        else $error("displacement timing wrong");
    index_time_a: assert property (rom_valid && job_q.kind == EAMT_KIND_EA &&
        (job_q.src == EAMT_INDEX || job_q.src == EAMT_PC_INDEX)
        |-> rom_time.clocks == (job_q.long_sz ? 6'h0E : 6'h0A))
        else $error("indexed timing wrong");
    move_word_a: assert property (rom_valid &&
        job_q.kind == EAMT_KIND_MOVE && !job_q.long_sz &&
        job_q.src == EAMT_ABS_L && job_q.dst == EAMT_ABS_L
        |-> rom_time == '{6'h1C, 3'h6, 2'h1})
        else $error("word move timing wrong");
    move_long_a: assert property (rom_valid &&
        job_q.kind == EAMT_KIND_MOVE && job_q.long_sz &&
        job_q.src == EAMT_DREG && job_q.dst == EAMT_PREDEC
        |-> rom_time == '{6'h0E, 3'h1, 2'h2})
        else $error("long move timing wrong");

    ea_done_c: cover property (done && job_q.kind == EAMT_KIND_EA);
    wait_move_c: cover property (done && job_q.kind == EAMT_KIND_MOVE &&
        waits_q != '0);
    long_move_c: cover property (done && job_q.long_sz &&
        wr_cnt_q == 2'h2);

endmodule // eamt_seq

/* sim/eamt_mem_model.sv */
`timescale 1ns/1ps
module eamt_mem_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // processor bus from the sequencer
    input  wire logic       bus_cyc,
    input  wire logic       bus_write,
    input  wire logic [1:0] bus_phase,
    output logic            mem_wait,
    // wait budget per bus cycle and observed traffic
    input  wire logic [3:0] n_wait,
    output logic [7:0]      rd_cnt,
    output logic [7:0]      wr_cnt
);
    import eamt_pkg::*;

    logic [3:0] left_q;

    // hold off completion of the last phase until the budget is spent
    assign mem_wait = bus_cyc && (bus_phase == EAMT_PH_LAST)
                      && (left_q != 4'h0);

    // reload budget outside the last phase, count finished cycles
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            left_q <= 4'h0;
            rd_cnt <= 8'h00;
            wr_cnt <= 8'h00;
        end else if (bus_cyc && bus_phase == EAMT_PH_LAST) begin
            if (mem_wait) begin
                left_q <= left_q - 4'h1;
            end else if (bus_write) begin
                wr_cnt <= wr_cnt + 8'h01;
            end else begin
                rd_cnt <= rd_cnt + 8'h01;
            end
        end else begin
            left_q <= n_wait;
        end
    end
endmodule // eamt_mem_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import eamt_pkg::*;

    localparam int CW = 16;
    // expected address evaluation per mode, byte and word
    localparam int EA_C [12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};
    localparam int EA_R [12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};

    logic            core_clk;
    logic            nrst;
    logic            req_valid;
    eamt_req_t       req;
    logic            req_ready;
    logic            bus_cyc;
    logic            bus_write;
    logic [1:0]      bus_phase;
    logic            mem_wait;
    logic            done;
    logic [CW-1:0]   total_clks;
    logic [CW-1:0]   wait_clks;
    logic [2:0]      reads_done;
    logic [1:0]      writes_done;
    logic [3:0]      n_wait;
    logic [7:0]      rd_cnt;
    logic [7:0]      wr_cnt;
    int              n_errors;
    int              total_checks;

    eamt_seq #(.CNT_W(CW)) dut (.core_clk(core_clk), .nrst(nrst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .bus_cyc(bus_cyc), .bus_write(bus_write), .bus_phase(bus_phase),
        .mem_wait(mem_wait), .done(done), .total_clks(total_clks),
        .wait_clks(wait_clks), .reads_done(reads_done),
        .writes_done(writes_done));

    eamt_mem_model mem (.core_clk(core_clk), .nrst(nrst),
        .bus_cyc(bus_cyc), .bus_write(bus_write), .bus_phase(bus_phase),
        .mem_wait(mem_wait), .n_wait(n_wait), .rd_cnt(rd_cnt),
        .wr_cnt(wr_cnt));

    // free running clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // verdict and end of run
    task report_and_stop;
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one comparison
    task chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // bounded wait for done, busy must refuse new requests
    task wait_done(output int cyc);
        cyc = 1;
        while (done !== 1'b1 && cyc < 400) begin
            chk(req_ready === 1'b0, "ready while busy");
            @(negedge core_clk);
            cyc++;
        end
        if (done !== 1'b1) begin
            chk(1'b0, "done never came");
            report_and_stop();
        end
    endtask

    // compare the job outcome with the expected figures
    task judge(input int c, r, w, nw, cyc, rd0, wr0);
        int wt;
        wt = nw * (r + w);
        chk(cyc == 2 + c + wt, "done latency");
        chk(total_clks === CW'(c + wt), "total clocks");
        chk(wait_clks === CW'(wt), "wait clocks");
        chk(reads_done === 3'(r), "read count");
        chk(writes_done === 2'(w), "write count");
        chk((rd_cnt - 8'(rd0)) === 8'(r), "reads on bus");
        chk((wr_cnt - 8'(wr0)) === 8'(w), "writes on bus");
    endtask

    // one job with a given wait budget
    task run_job(input eamt_req_t r, input int nw, c, rr, w);
        int cyc;
        int rd0;
        int wr0;
        @(negedge core_clk);
        n_wait = 4'(nw);
        req = r;
        req_valid = 1'b1;
        rd0 = rd_cnt;
        wr0 = wr_cnt;
        chk(req_ready === 1'b1, "not ready");
        @(negedge core_clk);
        req_valid = 1'b0;
        wait_done(cyc);
        judge(c, rr, w, nw, cyc, rd0, wr0);
    endtask

    // every mode, word without waits and long with two waits a cycle
    task scen_ea;
        eamt_req_t r;
        for (int i = 0; i < 12; i++) begin
            r = '{EAMT_KIND_EA, 1'b0, eamt_mode_t'(i), EAMT_DREG};
            run_job(r, 0, EA_C[i], EA_R[i], 0);
            r.long_sz = 1'b1;
            run_job(r, 2, EA_C[i] + (i > 1 ? 4 : 0),
                    EA_R[i] + (i > 1 ? 1 : 0), 0);
        end
    endtask

    // move helper
    task mv(input eamt_mode_t s, d, input bit l, input int nw, c, r, w);
        run_job('{EAMT_KIND_MOVE, l, s, d}, nw, c, r, w);
    endtask

    // move figures, some stretched by waits
    task scen_move;
        mv(EAMT_DREG, EAMT_AREG, 1'b0, 0, 4, 1, 0);
        mv(EAMT_DREG, EAMT_IND, 1'b0, 0, 8, 1, 1);
        mv(EAMT_ABS_L, EAMT_ABS_L, 1'b0, 0, 28, 6, 1);
        mv(EAMT_DREG, EAMT_IND, 1'b1, 0, 12, 1, 2);
        mv(EAMT_DREG, EAMT_PREDEC, 1'b1, 0, 14, 1, 2);
        mv(EAMT_ABS_L, EAMT_ABS_L, 1'b1, 0, 36, 7, 2);
        mv(EAMT_ABS_L, EAMT_ABS_L, 1'b1, 1, 36, 7, 2);
        mv(EAMT_DREG, EAMT_PREDEC, 1'b1, 3, 14, 1, 2);
    endtask

    // request held high across a job, next one taken right after
    task scen_b2b;
        int cyc;
        int rd0;
        int wr0;
        @(negedge core_clk);
        n_wait = 4'h0;
        req = '{EAMT_KIND_EA, 1'b1, EAMT_IND, EAMT_DREG};
        req_valid = 1'b1;
        rd0 = rd_cnt;
        wr0 = wr_cnt;
        @(negedge core_clk);
        req = '{EAMT_KIND_MOVE, 1'b0, EAMT_DREG, EAMT_IND};
        wait_done(cyc);
        judge(8, 2, 0, 0, cyc, rd0, wr0);
        rd0 = rd_cnt;
        wr0 = wr_cnt;
        @(negedge core_clk);
        chk(req_ready === 1'b1, "not ready after done");
        @(negedge core_clk);
        req_valid = 1'b0;
        wait_done(cyc);
        judge(8, 1, 1, 0, cyc, rd0, wr0);
    endtask

    // reset in mid-job, then a normal job
    task scen_reset;
        @(negedge core_clk);
        req = '{EAMT_KIND_MOVE, 1'b1, EAMT_ABS_L, EAMT_ABS_L};
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        repeat (10) @(negedge core_clk);
        nrst = 1'b0;
        @(negedge core_clk);
        chk(req_ready === 1'b1 && bus_cyc === 1'b0, "reset idle");
        chk(done === 1'b0 && total_clks === '0, "reset outputs");
        nrst = 1'b1;
        run_job('{EAMT_KIND_EA, 1'b0, EAMT_IND, EAMT_DREG}, 1, 4, 1, 0);
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req = '0;
        n_wait = 4'h0;
        n_errors = 0;
        total_checks = 0;
        repeat (20) @(negedge core_clk);
        nrst = 1'b1;
        scen_ea();
        scen_move();
        scen_b2b();
        scen_reset();
        report_and_stop();
    end
endmodule // tb_top
